// ===== verilog/cct_pkg.sv
// shared constants and types of the clock controller
package cct_pkg;

   // =========================================================
   // register offsets
   localparam logic [7:0] CCT_ADDR_CTRL = 8'h2C;
   localparam logic [7:0] CCT_ADDR_TONE = 8'h2D;
   localparam logic [7:0] CCT_ADDR_EVT_STAT = 8'h2E;
   localparam logic [7:0] CCT_ADDR_EVT_MASK = 8'h2F;

   // =========================================================
   // reset values
   localparam logic [7:0] CCT_CTRL_RST = 8'h00;
   localparam logic [7:0] CCT_TONE_RST = 8'h00;
   localparam logic [7:0] CCT_EVT_RST = 8'h00;

   // =========================================================
   // event bit positions in the event status register
   localparam int CCT_EVT_TICK = 0;
   localparam int CCT_EVT_PER = 1;
   localparam int CCT_EVT_WAKE = 2;
   localparam int CCT_EVT_W = 3;

   // =========================================================
   // timing counts in oscillator cycles
   localparam int unsigned CCT_TICK_DIV0 = 32'h0000_3E80;
   localparam int unsigned CCT_TICK_DIV1 = 32'h0000_7D00;
   localparam int unsigned CCT_TICK_DIV2 = 32'h0001_3880;
   localparam int unsigned CCT_TICK_DIV3 = 32'h0003_0D40;
   localparam int unsigned CCT_TONE_HALF1 = 32'h0000_07D0;
   localparam int unsigned CCT_TONE_HALF2 = 32'h0000_0FA0;
   localparam int unsigned CCT_TONE_HALF3 = 32'h0000_1F40;
   localparam int CCT_CNT_W = 18;

   // =========================================================
   // types
   typedef struct packed {
      logic       clk_out_en;
      logic [1:0] slow_divider;
      logic       slow_select;
      logic [1:0] period_select;
      logic       tick_irq_enable;
      logic       tick_flag;
   } cct_ctrl_t;

   typedef struct packed {
      logic [5:0] reserved;
      logic [1:0] tone_select;
   } cct_tone_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } cct_bus_req_t;

   typedef enum logic [1:0] {
      CCT_RUN       = 2'b00,
      CCT_WAIT      = 2'b01,
      CCT_ACT_HALT  = 2'b10,
      CCT_HALT      = 2'b11
   } cct_mode_t;

endpackage

// ===== verilog/cct_divider.sv
// free-running modulo counter with terminal pulse
`timescale 1ns/1ns
module cct_divider import cct_pkg::*; #(
   parameter int WIDTH = CCT_CNT_W
) (
   input  wire logic             clk,     // oscillator clock
   input  wire logic             sys_rst, // sync reset, high
   input  wire logic             run,     // count enable
   input  wire logic             clear,   // back to zero
   input  wire logic [WIDTH-1:0] limit,   // cycles per period
   output logic                  wrap     // last cycle of period
);

   logic [WIDTH-1:0] cnt;
   logic [WIDTH-1:0] next_cnt;

   assign wrap = run && !clear && (cnt >= limit - WIDTH'(1));

   always_comb begin
      next_cnt = cnt;
      if (clear) begin
         next_cnt = '0;
      end else if (wrap) begin
         next_cnt = '0;
      end else if (run) begin
         next_cnt = cnt + WIDTH'(1);
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt <= '0;
      end else begin
         cnt <= next_cnt;
      end
   end

   a_div_hold : assert property (@(posedge clk) disable iff (sys_rst)
      !run && !clear |=> cnt == $past(cnt)) else $error("divider moved while stopped");

endmodule // cct_divider

// ===== verilog/cct_evt_irq.sv
// sticky event status, mask and interrupt line
`timescale 1ns/1ns
module cct_evt_irq import cct_pkg::*; (
   input  wire logic                 clk,     // oscillator clock
   input  wire logic                 sys_rst, // sync reset, high
   input  wire logic [CCT_EVT_W-1:0] evt,     // event pulses
   input  wire logic                 wr_stat, // write-one-to-clear
   input  wire logic                 wr_mask, // mask write
   input  wire logic [7:0]           wdata,   // write data
   output logic      [7:0]           stat,    // sticky status
   output logic      [7:0]           mask,    // enable mask
   output logic                      irq      // level request
);

   logic [7:0] next_stat;
   logic [7:0] next_mask;

   always_comb begin
      next_stat = stat;
      next_mask = mask;
      if (wr_stat) begin
         next_stat = stat & ~wdata;
      end
      // set wins over clear
      next_stat[CCT_EVT_W-1:0] = next_stat[CCT_EVT_W-1:0] | evt;
      next_stat[7:CCT_EVT_W] = '0;
      if (wr_mask) begin
         next_mask = {{(8-CCT_EVT_W){1'b0}}, wdata[CCT_EVT_W-1:0]};
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stat <= CCT_EVT_RST;
         mask <= CCT_EVT_RST;
      end else begin
         stat <= next_stat;
         mask <= next_mask;
      end
   end

   assign irq = |(stat & mask);

endmodule // cct_evt_irq

// ===== verilog/cct_clock_ctrl.sv
// main clock controller: tick time base, slow core clock, clock out, tone
// =========================================================
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
module cct_clock_ctrl import cct_pkg::*; #(
   parameter int unsigned TICK_DIV0  = CCT_TICK_DIV0,
   parameter int unsigned TICK_DIV1  = CCT_TICK_DIV1,
   parameter int unsigned TICK_DIV2  = CCT_TICK_DIV2,
   parameter int unsigned TICK_DIV3  = CCT_TICK_DIV3,
   parameter int unsigned TONE_HALF1 = CCT_TONE_HALF1,
   parameter int unsigned TONE_HALF2 = CCT_TONE_HALF2,
   parameter int unsigned TONE_HALF3 = CCT_TONE_HALF3
) (
   input  wire logic         clk,             // oscillator clock
   input  wire logic         sys_rst,         // sync reset, high
   input  wire cct_bus_req_t bus,             // register request
   output logic      [7:0]   rdata,           // read data, next cycle
   input  wire logic         global_irq_mask, // processor mask active
   input  wire logic         wait_exec,       // wait instruction pulse
   input  wire logic         halt_exec,       // halt instruction pulse
   input  wire logic         ext_wake,        // halt-capable interrupt
   output cct_mode_t         power_mode,      // current power mode
   output logic              core_clk_en,     // one pulse per core cycle
   output logic              tick_irq,        // tick interrupt request
   output logic              wake_req,        // wake from wait/active-halt
   output logic              irq,             // event interrupt
   output logic              clk_out_pin,     // clock out level
   output logic              clk_out_oe,      // clock out drive enable
   output logic              tone_pin,        // tone level
   output logic              tone_oe          // tone drive enable
);

   // =========================================================
   // state
   cct_ctrl_t            ctrl;
   cct_ctrl_t            next_ctrl;
   cct_tone_t            tone;
   cct_tone_t            next_tone;
   cct_mode_t            mode;
   cct_mode_t            next_mode;
   logic [1:0]           act_per;
   logic [1:0]           next_act_per;
   logic [3:0]           slow_cnt;
   logic [3:0]           next_slow_cnt;
   logic                 tone_lvl;
   logic                 next_tone_lvl;
   logic                 clk_out_q;
   logic                 next_clk_out_q;
   logic [7:0]           next_rdata;
   logic [CCT_CNT_W-1:0] tick_limit;
   logic [CCT_CNT_W-1:0] tone_limit;
   logic                 tick_wrap;
   logic                 tone_wrap;
   logic                 regs_live;
   logic                 osc_run;
   logic                 tick_pend;
   logic                 rd_ctrl;
   logic [3:0]           slow_mask;
   logic [CCT_EVT_W-1:0] evt;
   logic [7:0]           evt_stat;
   logic [7:0]           evt_mask;

   assign regs_live = (mode == CCT_RUN) || (mode == CCT_WAIT);
   assign osc_run = (mode != CCT_HALT);
   assign rd_ctrl = bus.rd && (bus.addr == CCT_ADDR_CTRL) && regs_live;
   assign tick_pend = ctrl.tick_flag && ctrl.tick_irq_enable;

   // =========================================================
   // time base
   always_comb begin
      unique case (act_per)
         2'b00: tick_limit = CCT_CNT_W'(TICK_DIV0);
         2'b01: tick_limit = CCT_CNT_W'(TICK_DIV1);
         2'b10: tick_limit = CCT_CNT_W'(TICK_DIV2);
         2'b11: tick_limit = CCT_CNT_W'(TICK_DIV3);
      endcase
   end

   cct_divider #(.WIDTH(CCT_CNT_W)) u_tick (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (osc_run),
      .clear   (1'b0),
      .limit   (tick_limit),
      .wrap    (tick_wrap)
   );

   // =========================================================
   // tone
   always_comb begin
      unique case (tone.tone_select)
         2'b01:   tone_limit = CCT_CNT_W'(TONE_HALF1);
         2'b10:   tone_limit = CCT_CNT_W'(TONE_HALF2);
         2'b11:   tone_limit = CCT_CNT_W'(TONE_HALF3);
         2'b00:   tone_limit = CCT_CNT_W'(TONE_HALF1);
      endcase
   end

   cct_divider #(.WIDTH(CCT_CNT_W)) u_tone (
      .clk     (clk),
      .sys_rst (sys_rst),
      .run     (osc_run),
      .clear   (tone.tone_select == 2'b00),
      .limit   (tone_limit),
      .wrap    (tone_wrap)
   );

   // =========================================================
   // registers and read path
   always_comb begin
      next_ctrl = ctrl;
      next_tone = tone;
      next_act_per = act_per;
      next_rdata = 8'h00;
      if (bus.wr && regs_live && bus.addr == CCT_ADDR_CTRL) begin
         next_ctrl = cct_ctrl_t'(bus.wdata);
         next_ctrl.tick_flag = ctrl.tick_flag;
      end
      if (bus.wr && regs_live && bus.addr == CCT_ADDR_TONE) begin
         next_tone.tone_select = bus.wdata[1:0];
         next_tone.reserved = '0;
      end
      if (rd_ctrl) begin
         next_ctrl.tick_flag = 1'b0;
      end
      if (tick_wrap) begin
         next_ctrl.tick_flag = 1'b1;
         next_act_per = ctrl.period_select;
      end
      if (bus.rd) begin
         unique case (bus.addr)
            CCT_ADDR_CTRL:     next_rdata = ctrl;
            CCT_ADDR_TONE:     next_rdata = tone;
            CCT_ADDR_EVT_STAT: next_rdata = evt_stat;
            CCT_ADDR_EVT_MASK: next_rdata = evt_mask;
            default:           next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         ctrl <= cct_ctrl_t'(CCT_CTRL_RST);
         tone <= cct_tone_t'(CCT_TONE_RST);
         act_per <= 2'b00;
         rdata <= 8'h00;
      end else begin
         ctrl <= next_ctrl;
         tone <= next_tone;
         act_per <= next_act_per;
         rdata <= next_rdata;
      end
   end

   // =========================================================
   // power modes
   always_comb begin
      next_mode = mode;
      unique case (mode)
         CCT_RUN: begin
            if (halt_exec) begin
               next_mode = ctrl.tick_irq_enable ? CCT_ACT_HALT : CCT_HALT;
            end else if (wait_exec) begin
               next_mode = CCT_WAIT;
            end
         end
         CCT_WAIT: begin
            if (tick_pend || ext_wake) begin
               next_mode = CCT_RUN;
            end
         end
         CCT_ACT_HALT: begin
            if (tick_pend || ext_wake) begin
               next_mode = CCT_RUN;
            end
         end
         CCT_HALT: begin
            if (ext_wake) begin
               next_mode = CCT_RUN;
            end
         end
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         mode <= CCT_RUN;
      end else begin
         mode <= next_mode;
      end
   end

   assign power_mode = mode;
   assign wake_req = tick_pend && (mode == CCT_WAIT || mode == CCT_ACT_HALT);
   assign tick_irq = tick_pend && !global_irq_mask;

   // =========================================================
   // slow core clock, clock out, tone pin
   assign slow_mask = 4'h1 << ctrl.slow_divider;
   always_comb begin
      next_slow_cnt = slow_cnt;
      next_clk_out_q = clk_out_q;
      next_tone_lvl = tone_lvl;
      if (osc_run) begin
         next_slow_cnt = slow_cnt + 4'h1;
         if (ctrl.slow_select) begin
            next_clk_out_q = next_slow_cnt[ctrl.slow_divider];
         end else begin
            next_clk_out_q = !clk_out_q;
         end
      end
      if (tone.tone_select == 2'b00) begin
         next_tone_lvl = 1'b0;
      end else if (tone_wrap) begin
         next_tone_lvl = !tone_lvl;
      end
   end

   always_ff @(posedge clk) begin
      if (sys_rst) begin
         slow_cnt <= 4'h0;
         clk_out_q <= 1'b0;
         tone_lvl <= 1'b0;
      end else begin
         slow_cnt <= next_slow_cnt;
         clk_out_q <= next_clk_out_q;
         tone_lvl <= next_tone_lvl;
      end
   end

   assign core_clk_en = osc_run && (!ctrl.slow_select ||
                        ((slow_cnt & ((slow_mask << 1) - 4'h1)) == ((slow_mask << 1) - 4'h1)));
   assign clk_out_oe = ctrl.clk_out_en && (mode != CCT_ACT_HALT);
   assign clk_out_pin = clk_out_q && clk_out_oe;
   assign tone_oe = (tone.tone_select != 2'b00);
   assign tone_pin = tone_lvl;

   // =========================================================
   // event interrupt
   assign evt[CCT_EVT_TICK] = tick_wrap;
   assign evt[CCT_EVT_PER] = tick_wrap && (ctrl.period_select != act_per);
   assign evt[CCT_EVT_WAKE] = (mode != CCT_RUN) && (next_mode == CCT_RUN);

   cct_evt_irq u_evt (
      .clk     (clk),
      .sys_rst (sys_rst),
      .evt     (evt),
      .wr_stat (bus.wr && bus.addr == CCT_ADDR_EVT_STAT),
      .wr_mask (bus.wr && bus.addr == CCT_ADDR_EVT_MASK),
      .wdata   (bus.wdata),
      .stat    (evt_stat),
      .mask    (evt_mask),
      .irq     (irq)
   );

   // =========================================================
   // checks
   a_flag_set : assert property (@(posedge clk) disable iff (sys_rst)
      tick_wrap |=> ctrl.tick_flag) else $error("tick flag not set at period end");

   a_read_clears : assert property (@(posedge clk) disable iff (sys_rst)
      rd_ctrl && !tick_wrap |=> !ctrl.tick_flag) else $error("read did not clear flag");

   a_irq_gate : assert property (@(posedge clk) disable iff (sys_rst)
      tick_irq |-> ctrl.tick_flag && ctrl.tick_irq_enable && !global_irq_mask)
      else $error("tick request without its conditions");

   a_period_hold : assert property (@(posedge clk) disable iff (sys_rst)
      !tick_wrap |=> act_per == $past(act_per)) else $error("period changed mid-period");

   a_active_halt : assert property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_RUN && halt_exec |=>
      mode == ($past(ctrl.tick_irq_enable) ? CCT_ACT_HALT : CCT_HALT))
      else $error("wrong halt kind entered");

   a_halt_stays : assert property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_HALT && !ext_wake |=> mode == CCT_HALT && !tick_wrap)
      else $error("left full halt without halt-capable wake");

   a_frozen_regs : assert property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_ACT_HALT && !tick_wrap |=> ctrl == $past(ctrl) && tone == $past(tone))
      else $error("registers moved in active-halt");

   a_clkout_off : assert property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_ACT_HALT |-> !clk_out_oe && !clk_out_pin)
      else $error("clock out active in active-halt");

   a_wait_wake : assert property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_WAIT && tick_pend |=> mode == CCT_RUN) else $error("tick did not end wait");

   a_tone_off : assert property (@(posedge clk) disable iff (sys_rst)
      tone.tone_select == 2'b00 |=> !tone_lvl) else $error("tone running while off");

   a_irq_holds : assert property (@(posedge clk) disable iff (sys_rst)
      tick_irq && !rd_ctrl && !global_irq_mask && $stable(ctrl.tick_irq_enable) |=>
      tick_irq || !ctrl.tick_irq_enable || global_irq_mask)
      else $error("tick request dropped early");

   c_tick : cover property (@(posedge clk) disable iff (sys_rst) tick_wrap ##1 rd_ctrl);
   c_act_wake : cover property (@(posedge clk) disable iff (sys_rst)
      mode == CCT_ACT_HALT ##1 mode == CCT_RUN);
   c_tone_edge : cover property (@(posedge clk) disable iff (sys_rst) tone_wrap);
   c_per_switch : cover property (@(posedge clk) disable iff (sys_rst) evt[CCT_EVT_PER]);

endmodule // cct_clock_ctrl

// ===== tb/cct_pin_partner.sv
// pin-side model: listener on the tone and clock-out pins
`timescale 1ns/1ns
module cct_pin_partner (
   input  wire logic        clk,        // oscillator clock
   input  wire logic        sys_rst,    // sync reset, high
   input  wire logic        tone_wire,  // tone pin level, pulled up
   input  wire logic        co_wire,    // clock-out pin level, pulled up
   output logic      [15:0] tone_half,  // last tone half period
   output logic      [15:0] tone_edges, // tone transitions seen
   output logic      [15:0] co_edges    // clock-out transitions seen
);
   logic        tone_q;
   logic        co_q;
   logic [15:0] run;

   // =========================================================
   // edge and half-period measurement
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         tone_q     <= 1'b1;
         co_q       <= 1'b1;
         run        <= 16'h0000;
         tone_half  <= 16'h0000;
         tone_edges <= 16'h0000;
         co_edges   <= 16'h0000;
      end else begin
         tone_q <= tone_wire;
         co_q   <= co_wire;
         if (tone_wire != tone_q) begin
            tone_half  <= run;
            tone_edges <= tone_edges + 16'h0001;
            run        <= 16'h0001;
         end else begin
            run <= run + 16'h0001;
         end
         if (co_wire != co_q) begin
            co_edges <= co_edges + 16'h0001;
         end
      end
   end
endmodule // cct_pin_partner

// ===== tb/cct_clock_ctrl_tb_top.sv
// self-checking bench of the clock controller
`timescale 1ns/1ns
module cct_clock_ctrl_tb_top import cct_pkg::*; ;
   localparam int unsigned TDIV [4] = '{16, 32, 80, 200};
   localparam int unsigned THALF [4] = '{0, 4, CCT_TONE_HALF2, CCT_TONE_HALF3};

   logic         clk;
   logic         sys_rst;
   cct_bus_req_t bus;
   logic [7:0]   rdata;
   logic         global_irq_mask;
   logic         wait_exec;
   logic         halt_exec;
   logic         ext_wake;
   cct_mode_t    power_mode;
   logic         core_clk_en;
   logic         tick_irq;
   logic         wake_req;
   logic         irq;
   logic         clk_out_pin;
   logic         clk_out_oe;
   logic         tone_pin;
   logic         tone_oe;
   logic [15:0]  tone_half;
   logic [15:0]  tone_edges;
   logic [15:0]  co_edges;
   logic [7:0]   rd_v;
   logic [15:0]  e0;
   logic [31:0]  t0;
   logic [31:0]  t1;
   logic [31:0]  w;
   logic [31:0]  base;
   logic [1:0]   c;
   logic [1:0]   p;
   logic [1:0]   sd;
   logic         ss;
   int           n_fail = 0;
   int           cmp_count = 0;
   int           cyc = 0;
   int           seed;
   int           i;
   int           n;

   cct_clock_ctrl #(.TICK_DIV0(16), .TICK_DIV1(32), .TICK_DIV2(80), .TICK_DIV3(200),
                    .TONE_HALF1(4)) DUT (
      .clk(clk), .sys_rst(sys_rst), .bus(bus), .rdata(rdata),
      .global_irq_mask(global_irq_mask), .wait_exec(wait_exec), .halt_exec(halt_exec),
      .ext_wake(ext_wake), .power_mode(power_mode), .core_clk_en(core_clk_en),
      .tick_irq(tick_irq), .wake_req(wake_req), .irq(irq), .clk_out_pin(clk_out_pin),
      .clk_out_oe(clk_out_oe), .tone_pin(tone_pin), .tone_oe(tone_oe));

   // released pins float to the pull-up level
   cct_pin_partner u_partner (
      .clk(clk), .sys_rst(sys_rst), .tone_wire(tone_pin | !tone_oe),
      .co_wire(clk_out_pin | !clk_out_oe), .tone_half(tone_half),
      .tone_edges(tone_edges), .co_edges(co_edges));

   // =========================================================
   // clock, timeout, verdict
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end

   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 40000) begin
         n_fail = n_fail + 1;
         print_verdict();
      end
   end

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   // =========================================================
   // expectations, checks, bus and pulse drivers
   function automatic int unsigned exp_core(input logic [1:0] d, input logic s);
      return s ? (64 >> (d + 1)) : 64;
   endfunction

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
      end
   endtask

   task automatic acc(input logic [7:0] a, input logic [7:0] d, input logic wr);
      @(posedge clk);
      bus <= '{addr: a, wdata: d, wr: wr, rd: !wr};
      @(posedge clk);
      bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b0};
      #1;
      rd_v = rdata;
   endtask

   task automatic idle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task automatic pulse(input int which);
      @(posedge clk);
      wait_exec <= (which == 0);
      halt_exec <= (which == 1);
      ext_wake  <= (which == 2);
      @(posedge clk);
      wait_exec <= 1'b0;
      halt_exec <= 1'b0;
      ext_wake  <= 1'b0;
      #1;
   endtask

   // what 0: tick request high, what 1: back in run mode, what 2: wake request high
   task automatic wait_until(input int what, input int lim);
      int k;
      k = 0;
      while (k < lim && !((what == 0 && tick_irq === 1'b1) ||
                          (what == 1 && power_mode === CCT_RUN) ||
                          (what == 2 && wake_req === 1'b1))) begin
         @(posedge clk);
         #1;
         k++;
      end
      if (k >= lim) begin
         n_fail++;
         $display("[ERR] %0t wait limit reached", $time);
      end
   endtask

   // =========================================================
   // main sequence
   initial begin
      seed = 32'h1ace_3ff6;
      bus = '0;
      sys_rst = 1'b1;
      global_irq_mask = 1'b0;
      wait_exec = 1'b0;
      halt_exec = 1'b0;
      ext_wake = 1'b0;
      repeat (6) @(posedge clk);
      sys_rst <= 1'b0;
      #1;
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      chk(rd_v, CCT_CTRL_RST, "ctrl reset value");
      acc(CCT_ADDR_TONE, 8'h00, 1'b0);
      chk(rd_v, CCT_TONE_RST, "tone reset value");
      acc(8'h30, 8'h5a, 1'b1);
      acc(8'h30, 8'h00, 1'b0);
      chk(rd_v, 8'h00, "unmapped read");
      $display("test reset done");

      acc(CCT_ADDR_TONE, 8'hff, 1'b1);
      acc(CCT_ADDR_TONE, 8'h00, 1'b0);
      chk(rd_v, 8'h03, "tone reserved bits");
      for (i = 1; i < 4; i++) begin
         acc(CCT_ADDR_TONE, i[7:0], 1'b1);
         idle(2 * THALF[i] + 20);
         chk(tone_half, THALF[i], "tone half period");
         chk(tone_oe, 1'b1, "tone drive");
      end
      acc(CCT_ADDR_TONE, 8'h00, 1'b1);
      chk(tone_oe, 1'b0, "tone off");
      $display("test tone done");

      for (i = 0; i < 5; i++) begin
         sd = i[1:0];
         ss = (i < 4);
         acc(CCT_ADDR_CTRL, {1'b1, sd, ss, 4'h0}, 1'b1);
         idle(40);
         e0 = co_edges;
         n = 0;
         repeat (64) begin
            @(posedge clk);
            #1;
            n += core_clk_en;
         end
         chk(n, exp_core(sd, ss), "core clock rate");
         chk(clk_out_oe, 1'b1, "clock out drive");
         if (ss) chk(co_edges - e0, 64 >> sd, "clock out rate");
      end
      $display("test core clock done");

      acc(CCT_ADDR_EVT_MASK, 8'h01, 1'b1);
      acc(CCT_ADDR_CTRL, 8'h02, 1'b1);
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      wait_until(0, 300);
      chk(irq, 1'b1, "event irq");
      acc(CCT_ADDR_EVT_STAT, 8'h01, 1'b1);
      chk(irq, 1'b0, "event cleared");
      @(posedge clk);
      global_irq_mask <= 1'b1;
      #1;
      chk(tick_irq, 1'b0, "masked request");
      @(posedge clk);
      global_irq_mask <= 1'b0;
      #1;
      chk(tick_irq, 1'b1, "request held");
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      chk(rd_v[0], 1'b1, "flag set");
      chk(tick_irq, 1'b0, "read clears flag");
      $display("test events done");

      p = 2'b00;
      base = $random(seed);
      wait_until(0, 300);
      t0 = cyc;
      for (i = 0; i < 4; i++) begin
         c = base[1:0] + i[1:0];
         w = $random(seed);
         acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
         acc(CCT_ADDR_CTRL, {w[7:4], c, 2'b10}, 1'b1);
         wait_until(0, 300);
         t1 = cyc;
         chk(t1 - t0, TDIV[p], "old period kept");
         acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
         wait_until(0, 300);
         t0 = cyc;
         chk(t0 - t1, TDIV[c], "new period");
         p = c;
      end
      $display("test time base done");

      acc(CCT_ADDR_CTRL, 8'h8e, 1'b1);
      acc(CCT_ADDR_TONE, 8'h01, 1'b1);
      for (i = 0; i < 3; i++) begin
         wait_until(0, 300);
         acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      end
      pulse(0);
      chk(power_mode, CCT_WAIT, "wait entered");
      wait_until(2, 250);
      chk(power_mode, CCT_WAIT, "wake request in wait");
      wait_until(1, 250);
      chk(tick_irq, 1'b1, "tick ends wait");
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      e0 = tone_edges;
      pulse(1);
      chk(power_mode, CCT_ACT_HALT, "active halt entered");
      chk(clk_out_oe, 1'b0, "clock out off");
      acc(CCT_ADDR_CTRL, 8'h00, 1'b1);
      wait_until(2, 250);
      chk(power_mode, CCT_ACT_HALT, "wake request in active halt");
      wait_until(1, 250);
      chk(tick_irq, 1'b1, "tick ends active halt");
      chk(tone_edges != e0, 1'b1, "tone in active halt");
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      chk(rd_v[7:1], 7'h47, "registers frozen");
      acc(CCT_ADDR_CTRL, 8'h0c, 1'b1);
      pulse(1);
      chk(power_mode, CCT_HALT, "halt entered");
      acc(CCT_ADDR_CTRL, 8'h02, 1'b1);
      idle(300);
      chk(power_mode, CCT_HALT, "halt held");
      pulse(2);
      chk(power_mode, CCT_RUN, "other wake");
      acc(CCT_ADDR_CTRL, 8'h00, 1'b0);
      chk(rd_v, 8'h0c, "halt frozen");
      acc(CCT_ADDR_EVT_STAT, 8'h00, 1'b0);
      chk(rd_v, 8'h07, "event status");
      $display("test power modes done");
      print_verdict();
   end
endmodule // cct_clock_ctrl_tb_top
